// ---- core/dual_adc_sequencer.sv ----
`timescale 1ns/1ps
// How it works
// - A rising dwell clock edge while idle starts one conversion; one during a conversion is flagged as missed.
// - Quadrature mode holds and converts real and imaginary paths together.
// - Quadrature-off mode converts only the real path.
// - No alternating or sequential mode exists; controller never selects one.
// - Each converted path yields one 16-bit result word.
// - Dwell periods down to 150 kSPS are accepted.
// - Results captured into a holding register, stable until fetched.
// - Held results are sent while the next conversion runs.
// - A 32-bit result pair is sent as four bytes.
// - Real result goes first, low byte then high byte.
// - In quadrature mode imaginary result follows, low then high.
// - Control bus gives board reset, filter choice and mode choice.
// - Filter choices are 10k, 46.875k, 93.75k cutoff or bypass.
// - Rack strap low selects first rack type, high the second.
module dual_adc_sequencer (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Dwell clock pin from the acquisition unit
  input wire logic dwellClockInput,
  // Settings decoded from the control bus
  input wire logic boardResetCmd,
  input wire logic [1:0] filterWidthSetting,
  input wire logic acquisitionModeSetting,
  // Rack strap pin
  input wire logic rackTypeSelect,
  // Converter control and results
  output logic realHold,
  output logic imagHold,
  output logic realConvStart,
  output logic imagConvStart,
  input wire logic [15:0] realConvData,
  input wire logic [15:0] imagConvData,
  // Filter bank selects
  output logic [1:0] realFilterSel,
  output logic [1:0] imagFilterSel,
  output logic realFilterBypass,
  output logic imagFilterBypass,
  // Byte bus to the acquisition unit
  output logic [7:0] byteData,
  output logic byteValid,
  input wire logic byteReady,
  // Status
  output logic rackTypeMode,
  output logic quadActive,
  output logic convBusy,
  output logic dwellMissed,
  output logic resultOverrun
);

  logic localRst_n;
  logic dwellLevel;
  logic rackLevel;
  logic dwellPrev_q;
  logic dwellPrev_d;
  logic dwellRise;

  // Board reset command clears the block like a reset, except the pin synchronizers
  assign localRst_n = rst_n && !boardResetCmd;

  pin_synchronizer dwellSync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pinIn(dwellClockInput),
    .levelOut(dwellLevel)
  );

  pin_synchronizer rackSync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pinIn(rackTypeSelect),
    .levelOut(rackLevel)
  );

  // Rising edge of the filtered dwell clock
  always_comb begin
    dwellPrev_d = dwellLevel;
    dwellRise = dwellLevel && !dwellPrev_q;
  end

  always_ff @(posedge core_clk) begin
    if (!localRst_n) begin
      dwellPrev_q <= 1'b1;
    end else begin
      dwellPrev_q <= dwellPrev_d;
    end
  end

  // Settings and strap registers
  logic [1:0] filter_q;
  logic [1:0] filter_d;
  logic rack_q;
  logic rack_d;

  always_comb begin
    filter_d = filterWidthSetting;
    rack_d = rackLevel;
  end

  always_ff @(posedge core_clk) begin
    if (!localRst_n) begin
      filter_q <= dual_adc_sequencer_pkg::FILTER_10K;
      rack_q <= dual_adc_sequencer_pkg::RACK_FIRST;
    end else begin
      filter_q <= filter_d;
      rack_q <= rack_d;
    end
  end

  // Same filter for both paths; bypass code opens the bypass
  assign realFilterSel = filter_q;
  assign imagFilterSel = filter_q;
  assign realFilterBypass = (filter_q == dual_adc_sequencer_pkg::FILTER_BYPASS);
  assign imagFilterBypass = (filter_q == dual_adc_sequencer_pkg::FILTER_BYPASS);
  assign rackTypeMode = rack_q;

  // Conversion sequencer
  dual_adc_sequencer_pkg::conv_state_type convState_q;
  dual_adc_sequencer_pkg::conv_state_type convState_d;
  logic [8:0] convCnt_q;
  logic [8:0] convCnt_d;
  logic convQuad_q;
  logic convQuad_d;
  logic hold_q;
  logic hold_d;
  logic start_q;
  logic start_d;
  logic missed_q;
  logic missed_d;
  logic captureNow;

  // Held results
  logic [15:0] heldReal_q;
  logic [15:0] heldReal_d;
  logic [15:0] heldImag_q;
  logic [15:0] heldImag_d;
  logic heldValid_q;
  logic heldValid_d;
  logic heldQuad_q;
  logic heldQuad_d;
  logic overrun_q;
  logic overrun_d;

  // Serializer
  logic [1:0] byteIdx_q;
  logic [1:0] byteIdx_d;
  logic [7:0] pushData;
  logic pushValid;
  logic pushReady;
  logic lastByte;

  // Start on dwell edge; mode latched per conversion
  always_comb begin
    convState_d = convState_q;
    convCnt_d = convCnt_q;
    convQuad_d = convQuad_q;
    hold_d = hold_q;
    start_d = 1'b0;
    missed_d = missed_q;
    captureNow = 1'b0;
    case (convState_q)
      dual_adc_sequencer_pkg::CONV_IDLE: begin
        // A new edge is taken even while the held pair is still sent
        if (dwellRise) begin
          convState_d = dual_adc_sequencer_pkg::CONV_RUN;
          convCnt_d = dual_adc_sequencer_pkg::CNT_ZERO;
          // Only two modes decode; nothing selects sequential conversion
          convQuad_d = (acquisitionModeSetting ==
            dual_adc_sequencer_pkg::ACQ_MODE_QUAD_SIM);
          hold_d = 1'b1;
          start_d = 1'b1;
        end
      end
      dual_adc_sequencer_pkg::CONV_RUN: begin
        if (dwellRise) begin
          missed_d = 1'b1;
        end
        if (convCnt_q == dual_adc_sequencer_pkg::CONV_LAST) begin
          convState_d = dual_adc_sequencer_pkg::CONV_CAPTURE;
        end else begin
          convCnt_d = convCnt_q + dual_adc_sequencer_pkg::CNT_ONE;
        end
      end
      dual_adc_sequencer_pkg::CONV_CAPTURE: begin
        if (dwellRise) begin
          missed_d = 1'b1;
        end
        captureNow = 1'b1;
        hold_d = 1'b0;
        convState_d = dual_adc_sequencer_pkg::CONV_IDLE;
      end
      default: begin
        convState_d = dual_adc_sequencer_pkg::CONV_IDLE;
        hold_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!localRst_n) begin
      convState_q <= dual_adc_sequencer_pkg::CONV_IDLE;
      convCnt_q <= dual_adc_sequencer_pkg::CNT_ZERO;
      convQuad_q <= 1'b0;
      hold_q <= 1'b0;
      start_q <= 1'b0;
      missed_q <= 1'b0;
    end else begin
      convState_q <= convState_d;
      convCnt_q <= convCnt_d;
      convQuad_q <= convQuad_d;
      hold_q <= hold_d;
      start_q <= start_d;
      missed_q <= missed_d;
    end
  end

  // Both paths hold at one instant in quadrature; imaginary idle otherwise
  assign realHold = hold_q;
  assign imagHold = hold_q && convQuad_q;
  assign realConvStart = start_q;
  assign imagConvStart = start_q && convQuad_q;
  assign convBusy = (convState_q != dual_adc_sequencer_pkg::CONV_IDLE);
  assign quadActive = convQuad_q;
  assign dwellMissed = missed_q;

  // Holding register: loads only when empty, released after last byte
  always_comb begin
    heldReal_d = heldReal_q;
    heldImag_d = heldImag_q;
    heldValid_d = heldValid_q;
    heldQuad_d = heldQuad_q;
    overrun_d = overrun_q;
    if (pushValid && pushReady && lastByte) begin
      heldValid_d = 1'b0;
    end
    if (captureNow) begin
      if (heldValid_d) begin
        overrun_d = 1'b1;
      end else begin
        heldReal_d = realConvData;
        heldImag_d = convQuad_q ? imagConvData : dual_adc_sequencer_pkg::SAMPLE_ZERO;
        heldQuad_d = convQuad_q;
        heldValid_d = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!localRst_n) begin
      heldReal_q <= dual_adc_sequencer_pkg::SAMPLE_ZERO;
      heldImag_q <= dual_adc_sequencer_pkg::SAMPLE_ZERO;
      heldValid_q <= 1'b0;
      heldQuad_q <= 1'b0;
      overrun_q <= 1'b0;
    end else begin
      heldReal_q <= heldReal_d;
      heldImag_q <= heldImag_d;
      heldValid_q <= heldValid_d;
      heldQuad_q <= heldQuad_d;
      overrun_q <= overrun_d;
    end
  end

  assign resultOverrun = overrun_q;

  // Byte selection: real low, real high, imag low, imag high
  always_comb begin
    pushValid = heldValid_q;
    case (byteIdx_q)
      dual_adc_sequencer_pkg::BYTE_REAL_LO: pushData = heldReal_q[7:0];
      dual_adc_sequencer_pkg::BYTE_REAL_HI: pushData = heldReal_q[15:8];
      dual_adc_sequencer_pkg::BYTE_IMAG_LO: pushData = heldImag_q[7:0];
      dual_adc_sequencer_pkg::BYTE_IMAG_HI: pushData = heldImag_q[15:8];
      default: pushData = dual_adc_sequencer_pkg::BYTE_ZERO;
    endcase
    // Single mode stops after the real high byte
    lastByte = heldQuad_q ? (byteIdx_q == dual_adc_sequencer_pkg::BYTE_IMAG_HI)
      : (byteIdx_q == dual_adc_sequencer_pkg::BYTE_REAL_HI);
    byteIdx_d = byteIdx_q;
    if (pushValid && pushReady) begin
      byteIdx_d = lastByte ? dual_adc_sequencer_pkg::BYTE_REAL_LO : byteIdx_q + 2'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!localRst_n) begin
      byteIdx_q <= dual_adc_sequencer_pkg::BYTE_REAL_LO;
    end else begin
      byteIdx_q <= byteIdx_d;
    end
  end

  // Two-entry buffer absorbs receiver stalls
  two_entry_buffer #(
    .WIDTH(dual_adc_sequencer_pkg::BYTE_W),
    .DEPTH(2)
  ) byteBuffer (
    .core_clk(core_clk),
    .rst_n(localRst_n),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(pushData),
    .outValid(byteValid),
    .outReady(byteReady),
    .outData(byteData)
  );

endmodule

// ---- core/dual_adc_sequencer_pkg.sv ----
package dual_adc_sequencer_pkg;

  // Clock rate of core_clk
  localparam int CLK_HZ = 40_000_000;

  // Converter timing
  localparam int CONV_TIME_NS = 5300;
  localparam int CONV_CYCLES = (CONV_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int ACQ_TIME_NS = 2500;
  localparam int ACQ_CYCLES = (ACQ_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int MAX_RATE_SPS = 150_000;
  localparam int MIN_DWELL_CYCLES = CLK_HZ / MAX_RATE_SPS;
  localparam int CNT_W = 9;
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 9'h001;

  // Data widths
  localparam int SAMPLE_W = 16;
  localparam int BYTE_W = 8;
  localparam logic [SAMPLE_W-1:0] SAMPLE_ZERO = 16'h0000;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

  // Byte order within one result set
  localparam logic [1:0] BYTE_REAL_LO = 2'h0;
  localparam logic [1:0] BYTE_REAL_HI = 2'h1;
  localparam logic [1:0] BYTE_IMAG_LO = 2'h2;
  localparam logic [1:0] BYTE_IMAG_HI = 2'h3;

  // Acquisition mode: only two exist, no sequential mode
  localparam logic ACQ_MODE_QUAD_OFF = 1'b0;
  localparam logic ACQ_MODE_QUAD_SIM = 1'b1;

  // Rack strap levels
  localparam logic RACK_FIRST = 1'b0;
  localparam logic RACK_SECOND = 1'b1;

  // Filter width setting
  typedef enum logic [1:0] {
    FILTER_10K = 2'b00,
    FILTER_46K875 = 2'b01,
    FILTER_93K75 = 2'b10,
    FILTER_BYPASS = 2'b11
  } filter_width_type;

  // Conversion sequencer states
  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_RUN = 2'b01,
    CONV_CAPTURE = 2'b10
  } conv_state_type;

endpackage

// ---- core/pin_synchronizer.sv ----
`timescale 1ns/1ps
module pin_synchronizer (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Pin and filtered level
  input wire logic pinIn,
  output logic levelOut
);

  logic stage1_q;
  logic stage2_q;
  logic stage3_q;
  logic level_q;
  logic level_d;

  // Change accepted once second and third stages agree
  always_comb begin
    level_d = level_q;
    if (stage2_q == stage3_q) begin
      level_d = stage3_q;
    end
  end

  // Three-stage chain
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
      stage3_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      stage1_q <= pinIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      level_q <= level_d;
    end
  end

  assign levelOut = level_q;

endmodule

// ---- core/two_entry_buffer.sv ----
`timescale 1ns/1ps
module two_entry_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PTR_W:0] COUNT_FULL = (PTR_W + 1)'(DEPTH);
  localparam logic [PTR_W:0] COUNT_ONE = (PTR_W + 1)'(1);
  localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [PTR_W-1:0] wrPtr_q;
  logic [PTR_W-1:0] wrPtr_d;
  logic [PTR_W-1:0] rdPtr_q;
  logic [PTR_W-1:0] rdPtr_d;
  logic [PTR_W:0] count_q;
  logic [PTR_W:0] count_d;
  logic push;
  logic pop;

  // Honest full and empty
  assign inReady = (count_q != COUNT_FULL);
  assign outValid = (count_q != '0);
  assign outData = mem_q[rdPtr_q];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // Pointer and storage update
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_d[i] = mem_q[i];
    end
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    count_d = count_q;
    if (push) begin
      mem_d[wrPtr_q] = inData;
      wrPtr_d = (wrPtr_q == PTR_LAST) ? '0 : wrPtr_q + PTR_ONE;
    end
    if (pop) begin
      rdPtr_d = (rdPtr_q == PTR_LAST) ? '0 : rdPtr_q + PTR_ONE;
    end
    if (push && !pop) begin
      count_d = count_q + COUNT_ONE;
    end else if (pop && !push) begin
      count_d = count_q - COUNT_ONE;
    end
  end

  // Registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      mem_q <= mem_d;
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end

endmodule

// ---- bench/dual_adc_sequencer_asserts.sv ----
`timescale 1ns/1ps
module dual_adc_sequencer_asserts (
  // Clock and resets
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic boardResetCmd,
  // Settings and strap
  input wire logic [1:0] filterWidthSetting,
  input wire logic rackTypeSelect,
  // Converter control
  input wire logic realHold,
  input wire logic imagHold,
  input wire logic realConvStart,
  input wire logic imagConvStart,
  // Filter selects
  input wire logic [1:0] realFilterSel,
  input wire logic [1:0] imagFilterSel,
  input wire logic realFilterBypass,
  input wire logic imagFilterBypass,
  // Byte bus and status
  input wire logic [7:0] byteData,
  input wire logic byteValid,
  input wire logic byteReady,
  input wire logic rackTypeMode,
  input wire logic dwellMissed
);
  logic [8:0] holdCnt_q;
  logic [8:0] holdCnt_d;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n || boardResetCmd);
  // Length of the current hold level
  always_comb begin
    holdCnt_d = realHold ? holdCnt_q + 9'h001 : 9'h000;
  end
  always_ff @(posedge core_clk) begin
    holdCnt_q <= (!rst_n || boardResetCmd) ? 9'h000 : holdCnt_d;
  end
  // Start of a conversion, and a byte held back by the receiver
  sequence s_start;
    realConvStart && realHold;
  endsequence
  sequence s_stall;
    byteValid && !byteReady;
  endsequence
  // Conversion timing
  property p_startOne; realConvStart |=> !realConvStart; endproperty
  property p_startIdle; realConvStart |-> !$past(realHold); endproperty
  property p_holdRise; $rose(realHold) |-> s_start; endproperty
  // Hold covers every run count plus the capture cycle
  property p_holdLen;
    $fell(realHold) |-> holdCnt_q == 9'(dual_adc_sequencer_pkg::CONV_CYCLES + 1);
  endproperty
  property p_missSticky; dwellMissed |=> dwellMissed; endproperty
  a_startOne: assert property (p_startOne) else $error("start pulse too long");
  a_startIdle: assert property (p_startIdle) else $error("start while busy");
  a_holdRise: assert property (p_holdRise) else $error("hold without start");
  a_holdLen: assert property (p_holdLen) else $error("hold length wrong");
  a_missSticky: assert property (p_missSticky) else $error("missed flag lost");
  // Path pairing
  property p_imagStart; imagConvStart |-> realConvStart; endproperty
  property p_imagPair; realConvStart |-> imagHold == imagConvStart; endproperty
  property p_imagHold; imagHold |-> realHold; endproperty
  a_imagStart: assert property (p_imagStart) else $error("imag start alone");
  a_imagPair: assert property (p_imagPair) else $error("imag hold not paired");
  a_imagHold: assert property (p_imagHold) else $error("imag hold alone");
  // Byte bus, filter and strap
  property p_byteStall; s_stall |=> byteValid && $stable(byteData); endproperty
  property p_filterReg;
    1'b1 |=> realFilterSel == $past(filterWidthSetting) && imagFilterSel == realFilterSel;
  endproperty
  property p_bypass;
    realFilterBypass == (realFilterSel == 2'h3) && imagFilterBypass == realFilterBypass;
  endproperty
  property p_rack;
    (rackTypeSelect == $past(rackTypeSelect))[*8] |-> rackTypeMode == rackTypeSelect;
  endproperty
  a_byteStall: assert property (p_byteStall) else $error("stalled byte changed");
  a_filterReg: assert property (p_filterReg) else $error("filter select wrong");
  a_bypass: assert property (p_bypass) else $error("bypass decode wrong");
  a_rack: assert property (p_rack) else $error("rack mode wrong");
endmodule
bind dual_adc_sequencer dual_adc_sequencer_asserts chk_u (.core_clk, .rst_n, .boardResetCmd,
  .filterWidthSetting, .rackTypeSelect, .realHold, .imagHold, .realConvStart, .imagConvStart,
  .realFilterSel, .imagFilterSel, .realFilterBypass, .imagFilterBypass, .byteData, .byteValid,
  .byteReady, .rackTypeMode, .dwellMissed);

// ---- bench/acq_unit_model.sv ----
`timescale 1ns/1ps
module acq_unit_model (
  // Clock
  input wire logic core_clk,
  // Byte bus from the board
  input wire logic [7:0] byteData,
  input wire logic byteValid,
  output logic byteReady,
  // Dwell clock to the board
  output logic dwellClockInput,
  // Flow control chosen by the bench
  input wire logic stallOn,
  input wire logic slowOn
);
  logic [7:0] rxQ[$];
  logic [1:0] slowCnt = 2'h0;
  initial begin
    byteReady = 1'b0;
    dwellClockInput = 1'b0;
  end
  // Ready moves after the falling edge; slow mode is ready one cycle in four
  always @(negedge core_clk) begin
    slowCnt <= slowCnt + 2'h1;
    byteReady <= !stallOn && (!slowOn || slowCnt == 2'h3);
  end
  // Bytes taken on valid and ready
  always @(posedge core_clk) begin
    if (byteValid === 1'b1 && byteReady) begin
      rxQ.push_back(byteData);
    end
  end
  // One rising dwell edge, held well past the pin synchroniser
  task dwellPulse();
    @(negedge core_clk);
    dwellClockInput = 1'b1;
    repeat (40) @(negedge core_clk);
    dwellClockInput = 1'b0;
  endtask
endmodule

// ---- bench/test_dual_adc_sequencer.sv ----
`timescale 1ns/1ps
module test_dual_adc_sequencer;
  localparam int GAP = dual_adc_sequencer_pkg::MIN_DWELL_CYCLES - 40;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic boardResetCmd = 1'b0;
  logic [1:0] filterWidthSetting = 2'h0; // Bench is the only settings master
  logic acquisitionModeSetting = 1'b0;
  logic rackTypeSelect = 1'b0;
  logic [15:0] realConvData = 16'h0000;
  logic [15:0] imagConvData = 16'h0000;
  logic stallOn = 1'b0;
  logic slowOn = 1'b0;
  logic realHold, imagHold, realConvStart, imagConvStart, dwellClockInput;
  logic [1:0] realFilterSel, imagFilterSel;
  logic realFilterBypass, imagFilterBypass, byteValid, byteReady;
  logic [7:0] byteData;
  logic rackTypeMode, quadActive, convBusy, dwellMissed, resultOverrun;
  int n_mismatch = 0;
  int cmp_count = 0;
  int nStarts = 0;
  int nImag = 0;
  logic [7:0] expQ[$];
  // Clock and instances
  always #12.5 core_clk = ~core_clk;
  dual_adc_sequencer dut_u (.core_clk, .rst_n, .dwellClockInput, .boardResetCmd,
    .filterWidthSetting, .acquisitionModeSetting, .rackTypeSelect, .realHold, .imagHold,
    .realConvStart, .imagConvStart, .realConvData, .imagConvData, .realFilterSel,
    .imagFilterSel, .realFilterBypass, .imagFilterBypass, .byteData, .byteValid, .byteReady,
    .rackTypeMode, .quadActive, .convBusy, .dwellMissed, .resultOverrun);
  acq_unit_model acq_u (.core_clk, .byteData, .byteValid, .byteReady, .dwellClockInput,
    .stallOn, .slowOn);
  // Start pulse counters
  always @(posedge core_clk) begin
    nStarts += (realConvStart === 1'b1);
    nImag += (imagConvStart === 1'b1);
  end
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      n_mismatch++;
    end
  endtask
  task results();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task cycles(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // One conversion over a full dwell period
  task convert(input logic [15:0] r, input logic [15:0] i);
    realConvData = r;
    imagConvData = i;
    acq_u.dwellPulse();
    cycles(GAP);
  endtask
  task expectPair(input logic [15:0] r, input logic [15:0] i, input logic quad);
    expQ.push_back(r[7:0]);
    expQ.push_back(r[15:8]);
    if (quad) begin
      expQ.push_back(i[7:0]);
      expQ.push_back(i[15:8]);
    end
  endtask
  // Waits for the expected bytes, then compares count and order
  task drain();
    int n;
    n = 0;
    while (acq_u.rxQ.size() < expQ.size() && n < 3000) begin
      cycles(1);
      n++;
    end
    cycles(8);
    check("byteCount", acq_u.rxQ.size(), expQ.size());
    foreach (expQ[k]) begin
      check("byte", acq_u.rxQ[k], expQ[k]);
    end
    expQ = {};
    acq_u.rxQ = {};
  endtask
  task boardReset();
    boardResetCmd = 1'b1;
    cycles(2);
    boardResetCmd = 1'b0;
    cycles(1);
  endtask
  task scnSettings();
    check("reset", {byteValid, realHold, convBusy, dwellMissed, resultOverrun, byteData}, 0);
    for (int k = 0; k < 4; k++) begin
      filterWidthSetting = 2'(k);
      cycles(2);
      check("sel", {realFilterSel, imagFilterSel}, {2'(k), 2'(k)});
      check("bypass", {realFilterBypass, imagFilterBypass}, {2{k == 3}});
    end
    rackTypeSelect = 1'b1;
    cycles(10);
    check("rack", rackTypeMode, dual_adc_sequencer_pkg::RACK_SECOND);
    rackTypeSelect = 1'b0;
    cycles(10);
    check("rack", rackTypeMode, dual_adc_sequencer_pkg::RACK_FIRST);
  endtask
  // Stalled first pair drains while the next conversion runs
  task scnQuad();
    int s;
    s = nImag;
    acquisitionModeSetting = dual_adc_sequencer_pkg::ACQ_MODE_QUAD_SIM;
    stallOn = 1'b1;
    convert(16'hA5C3, 16'h7E19);
    realConvData = 16'h0F1E;
    imagConvData = 16'hD2B4;
    acq_u.dwellPulse();
    check("imagHold", imagHold, 1'b1);
    stallOn = 1'b0;
    expectPair(16'hA5C3, 16'h7E19, 1'b1);
    drain();
    check("overlap", realHold, 1'b1);
    cycles(GAP);
    expectPair(16'h0F1E, 16'hD2B4, 1'b1);
    drain();
    check("imagStarts", nImag - s, 2);
    check("noMiss", {dwellMissed, quadActive}, 2'h1);
  endtask
  task scnSingle();
    int s;
    s = nImag;
    acquisitionModeSetting = dual_adc_sequencer_pkg::ACQ_MODE_QUAD_OFF;
    realConvData = 16'h3C5A;
    imagConvData = 16'h9669;
    acq_u.dwellPulse();
    check("holds", {convBusy, quadActive, imagHold, realHold}, 4'h9);
    cycles(GAP);
    check("imagStarts", nImag - s, 0);
    expectPair(16'h3C5A, 16'h9669, 1'b0);
    drain();
  endtask
  // Dwell edge in mid-conversion is ignored and flagged
  task scnMissed();
    int s;
    s = nStarts;
    acquisitionModeSetting = dual_adc_sequencer_pkg::ACQ_MODE_QUAD_SIM;
    realConvData = 16'h8001;
    imagConvData = 16'h00FE;
    acq_u.dwellPulse();
    cycles(20);
    convert(16'h8001, 16'h00FE);
    check("starts", nStarts - s, 1);
    check("missed", dwellMissed, 1'b1);
    expectPair(16'h8001, 16'h00FE, 1'b1);
    drain();
    boardReset();
    check("missCleared", dwellMissed, 1'b0);
  endtask
  // Receiver stalls through two results; the older pair is kept
  task scnOverrun();
    stallOn = 1'b1;
    convert(16'h1357, 16'h2468);
    convert(16'hFEDC, 16'hBA98);
    check("overrun", resultOverrun, 1'b1);
    slowOn = 1'b1;
    stallOn = 1'b0;
    expectPair(16'h1357, 16'h2468, 1'b1);
    drain();
    boardReset();
    check("overrunCleared", resultOverrun, 1'b0);
  endtask
  // Main sequence
  initial begin
    cycles(4);
    rst_n = 1'b1;
    cycles(2);
    scnSettings();
    scnQuad();
    scnSingle();
    scnMissed();
    scnOverrun();
    results();
  end
  // Watchdog
  initial begin
    cycles(20000);
    n_mismatch++;
    results();
  end
endmodule
